// ### common/ncc_map.svh
`ifndef NCC_MAP_SVH
`define NCC_MAP_SVH

// Longest string that may be compared
`define NCC_STR_MAX_LEN   8'hFE
// Largest value that fits four decimal digits
`define NCC_DEC_MAX       16'h270F
// Largest value that fits a byte
`define NCC_BYTE_MAX      16'h00FF
`define NCC_ERR_NONE      16'h0000
`define NCC_ERR_INDIRECT  16'h0006
// Real exponent field that marks infinity or not-a-number
`define NCC_F_EXP_SPECIAL 8'hFF
`define NCC_F_EXP_BIAS    8'h7F
// Real exponent minus bias plus nine: shift that aligns 32 fraction bits
`define NCC_F_ALIGN       10'sh076
`define NCC_F_SHIFT_MAX   10'sh027

`endif

// ### common/ncc_pkg.sv
package ncc_pkg;

    typedef enum logic [3:0] {
        cmp_byte_op,
        cmp_int_op,
        cmp_dint_op,
        cmp_real_op,
        cmp_str_op,
        byte_to_int_op,
        int_to_byte_op,
        int_to_dint_op,
        dint_to_int_op,
        dint_to_real_op,
        decimal_to_int_op,
        int_to_decimal_op,
        real_round_op,
        real_chop_op
    } ncc_op_t;

    typedef enum logic [2:0] {
        rel_eq,
        rel_ne,
        rel_ge,
        rel_le,
        rel_gt,
        rel_lt
    } ncc_rel_t;

    typedef enum logic [1:0] {
        comb_load,
        comb_and,
        comb_or
    } ncc_comb_t;

    typedef enum logic [2:0] {
        st_idle,
        st_len_a,
        st_len_b,
        st_ch_a,
        st_ch_b
    } ncc_state_t;

    typedef struct packed {
        ncc_op_t     op;
        ncc_rel_t    rel;
        ncc_comb_t   comb;
        logic [31:0] in1;
        logic [31:0] in2;
        logic [15:0] area_end;
        logic        ptr_fault;
        logic        power_flow;
        logic        stack_top;
    } ncc_req_t;

    typedef struct packed {
        logic [31:0] value;
        logic        dest_we;
        logic        enable_out;
        logic        overflow_flag;
        logic        invalid_decimal_flag;
        logic [15:0] err_code;
        logic        fatal;
        logic        stack_top;
        logic        stack_push;
    } ncc_resp_t;

    typedef struct packed {
        ncc_state_t  st;
        ncc_req_t    req;
        ncc_resp_t   resp;
        logic        done;
        logic        busy;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  len_a;
        logic [7:0]  ch;
        logic [7:0]  idx;
    } ncc_regs_t;

endpackage

// ### core/ncc_unit.sv
// What this block does
// RULE1 - Byte comparisons treat both operands as unsigned.
// RULE2 - Integer, double-word and real comparisons are signed.
// RULE3 - A true compare loads, ANDs or ORs a one into the stack top.
// RULE4 - Sequencer gives both compare operands in one data type.
// RULE5 - A not-a-number real compare operand stops execution fatally.
// RULE6 - An illegal indirect reference in any compare stops execution fatally.
// RULE7 - Compares run whatever the incoming power flow is.
// RULE8 - A string longer than 254 characters stops execution fatally.
// RULE9 - A string running past its memory area stops execution fatally.
// RULE10 - Decimal to integer for 0..9999; otherwise invalid flag and enable-out low.
// RULE11 - Integer 0..9999 becomes four decimal digits; others are invalid.
// RULE12 - Signed 32-bit integer converts to a 32-bit real.
// RULE13 - Double to integer overflow sets flag, clears enable-out, keeps destination.
// RULE14 - Integer to double integer replicates the sign bit.
// RULE15 - Byte to integer zero-fills the upper bits.
// RULE16 - Rounding converts a real to the rounded double integer.
// RULE17 - Truncating converts a real keeping only the whole part.
// RULE18 - Indirect fault in a conversion reports code 0006, enable-out low.
// RULE19 - Rounding goes away from zero when the fraction is one half or more.
// RULE20 - Destination, flags and enable-out update together in one cycle; string compares set enable-out at take, the stack top at done.
`timescale 1ns/10ps
`include "ncc_map.svh"

module ncc_unit (
    input  wire logic              core_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              start_i,
    input  wire ncc_pkg::ncc_req_t req_i,
    input  wire logic [7:0]        mem_rdata_i,
    output ncc_pkg::ncc_resp_t     resp_o,
    output logic                   done_o,
    output logic                   busy_o,
    output logic                   mem_rd_o,
    output logic [15:0]            mem_addr_o
);
    import ncc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_nan(input logic [31:0] x);
        return (x[30:23] == `NCC_F_EXP_SPECIAL) && (x[22:0] != 23'h000000);
    endfunction

    // Order-preserving key for reals, both zeros equal
    function automatic logic [31:0] f_key(input logic [31:0] x);
        if (x[30:0] == 31'h00000000)
            return 32'h80000000;
        return x[31] ? ~x : (x | 32'h80000000);
    endfunction

    function automatic logic [1:0] num_lt_eq(input ncc_req_t q);
        logic [31:0] ka;
        logic [31:0] kb;
        ka = f_key(q.in1);
        kb = f_key(q.in2);
        // One data type per operation code [RULE4]
        case (q.op)
            cmp_byte_op: return {q.in1[7:0] < q.in2[7:0], q.in1[7:0] == q.in2[7:0]}; // [RULE1]
            cmp_int_op: return {$signed(q.in1[15:0]) < $signed(q.in2[15:0]),
                                q.in1[15:0] == q.in2[15:0]}; // [RULE2]
            cmp_real_op: return {ka < kb, ka == kb}; // [RULE2]
            default: return {$signed(q.in1) < $signed(q.in2), q.in1 == q.in2}; // [RULE2]
        endcase
    endfunction

    function automatic logic rel_hit(input ncc_rel_t rel, input logic lt, input logic eq);
        case (rel)
            rel_eq: return eq;
            rel_ne: return !eq;
            rel_ge: return !lt;
            rel_le: return lt | eq;
            rel_gt: return !lt && !eq;
            default: return lt;
        endcase
    endfunction

    function automatic logic stack_next(input ncc_comb_t c, input logic top, input logic hit);
        case (c)
            comb_and: return top & hit; // [RULE3]
            comb_or: return top | hit; // [RULE3]
            default: return hit; // [RULE3]
        endcase
    endfunction

    // High when the length byte plus characters run past the area end
    function automatic logic str_overrun(input logic [15:0] s, input logic [7:0] len,
                                         input logic [15:0] e);
        return ({1'b0, s} + {9'h000, len} + 17'h00001) > {1'b0, e};
    endfunction

    // Signed 32-bit integer to real, round to nearest even
    function automatic logic [31:0] i2f(input logic [31:0] d);
        logic [31:0] mag;
        logic [31:0] norm;
        logic [4:0]  msb;
        logic [7:0]  e;
        logic [24:0] r;
        mag = d[31] ? (~d + 32'h00000001) : d;
        msb = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (mag[i])
                msb = i[4:0];
        end
        norm = mag << (5'h1F - msb);
        r = {1'b0, norm[31:8]} + {24'h000000, norm[7] & ((|norm[6:0]) | norm[8])};
        e = `NCC_F_EXP_BIAS + {3'h0, msb};
        if (r[24]) begin
            e = e + 8'h01;
            r = r >> 1;
        end
        if (mag == 32'h00000000)
            return 32'h00000000;
        return {d[31], e, r[22:0]};
    endfunction

    // Real to double integer; top bit flags overflow or invalid input
    function automatic logic [32:0] f2i(input logic [31:0] x, input logic rnd);
        logic signed [9:0] e;
        logic [9:0]        ne;
        logic [63:0]       fx;
        logic [32:0]       mg;
        logic              big;
        e = $signed({2'h0, x[30:23]}) - `NCC_F_ALIGN;
        ne = 10'h000 - e;
        fx = {40'h0000000000, 1'b1, x[22:0]};
        big = (x[30:23] == `NCC_F_EXP_SPECIAL) || (e > `NCC_F_SHIFT_MAX);
        if (x[30:23] == 8'h00)
            fx = 64'h0000000000000000;
        else if (e >= 10'sh000)
            fx = fx << e[5:0];
        else if (e > -`NCC_F_SHIFT_MAX)
            fx = fx >> ne[5:0];
        else
            fx = 64'h0000000000000000;
        // Half or more of the magnitude goes away from zero [RULE19]
        mg = {1'b0, fx[63:32]} + {32'h00000000, rnd & fx[31]}; // [RULE16]
        big = big || (mg > (x[31] ? 33'h080000000 : 33'h07FFFFFFF));
        return {big, x[31] ? (~mg[31:0] + 32'h00000001) : mg[31:0]}; // [RULE17]
    endfunction

    // Four packed decimal digits to binary; top bit flags a bad digit
    function automatic logic [16:0] dec2bin(input logic [15:0] w);
        logic bad;
        bad = (w[15:12] > 4'h9) || (w[11:8] > 4'h9) || (w[7:4] > 4'h9) || (w[3:0] > 4'h9);
        return {bad, {12'h000, w[15:12]} * 16'h03E8 + {12'h000, w[11:8]} * 16'h0064
                     + {12'h000, w[7:4]} * 16'h000A + {12'h000, w[3:0]}};
    endfunction

    function automatic logic [15:0] bin2dec(input logic [15:0] v);
        logic [15:0] t3;
        logic [15:0] t2;
        logic [15:0] t1;
        logic [15:0] t0;
        t3 = v / 16'h03E8;
        t2 = (v / 16'h0064) % 16'h000A;
        t1 = (v / 16'h000A) % 16'h000A;
        t0 = v % 16'h000A;
        return {t3[3:0], t2[3:0], t1[3:0], t0[3:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    ncc_regs_t   r_reg;
    ncc_regs_t   r_next;
    logic [1:0]  num_le;
    logic        num_hit;
    logic        nan_fault;
    logic        take;
    logic [32:0] f_res;
    logic [16:0] dec_res;
    logic [31:0] cv_val;
    logic        cv_ovf;
    logic        cv_bad;
    logic        str_hit;

    assign num_le    = num_lt_eq(req_i);
    assign num_hit   = rel_hit(req_i.rel, num_le[1], num_le[0]);
    assign nan_fault = (req_i.op == cmp_real_op) && (is_nan(req_i.in1) || is_nan(req_i.in2));
    assign take      = start_i && (r_reg.st == st_idle) && !r_reg.resp.fatal;
    assign f_res     = f2i(req_i.in1, req_i.op == real_round_op);
    assign dec_res   = dec2bin(req_i.in1[15:0]);
    assign str_hit   = (r_reg.req.rel == rel_ne);

    always_comb begin
        cv_val = 32'h00000000;
        cv_ovf = 1'b0;
        cv_bad = 1'b0;
        case (req_i.op)
            byte_to_int_op: cv_val = {24'h000000, req_i.in1[7:0]}; // [RULE15]
            int_to_byte_op: begin
                cv_ovf = req_i.in1[15:0] > `NCC_BYTE_MAX;
                cv_val = {24'h000000, req_i.in1[7:0]};
            end
            int_to_dint_op: cv_val = {{16{req_i.in1[15]}}, req_i.in1[15:0]}; // [RULE14]
            dint_to_int_op: begin
                cv_ovf = (req_i.in1[31:15] != 17'h00000)
                         && (req_i.in1[31:15] != 17'h1FFFF); // [RULE13]
                cv_val = {16'h0000, req_i.in1[15:0]};
            end
            dint_to_real_op: cv_val = i2f(req_i.in1); // [RULE12]
            decimal_to_int_op: begin
                cv_bad = dec_res[16]; // [RULE10]
                cv_val = {16'h0000, dec_res[15:0]};
            end
            int_to_decimal_op: begin
                cv_bad = req_i.in1[15] || (req_i.in1[15:0] > `NCC_DEC_MAX); // [RULE11]
                cv_val = {16'h0000, bin2dec(req_i.in1[15:0])}; // [RULE11]
            end
            real_round_op, real_chop_op: begin
                cv_ovf = f_res[32];
                cv_val = f_res[31:0]; // [RULE16] [RULE17]
            end
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Results land in the same edge as done; a string compare sets enable_out, dest_we and err_code at take [RULE20]
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        case (r_reg.st)
            st_idle: begin
                if (take) begin
                    r_next.req = req_i;
                    r_next.resp.err_code = `NCC_ERR_NONE;
                    r_next.resp.dest_we = 1'b0;
                    r_next.resp.enable_out = 1'b1;
                    if (req_i.op == cmp_str_op && !req_i.ptr_fault) begin
                        r_next.st = st_len_a;
                        r_next.busy = 1'b1;
                        r_next.rd = 1'b1;
                        r_next.addr = req_i.in1[15:0];
                    end else if (req_i.op <= cmp_str_op) begin
                        // No power-flow gating on compares [RULE7]
                        r_next.done = 1'b1;
                        if (req_i.ptr_fault || nan_fault) begin
                            r_next.resp.fatal = 1'b1; // [RULE5] [RULE6]
                            r_next.resp.enable_out = 1'b0;
                        end else begin
                            r_next.resp.stack_top = stack_next(req_i.comb, req_i.stack_top,
                                                               num_hit); // [RULE3]
                            r_next.resp.stack_push = (req_i.comb == comb_load);
                        end
                    end else begin
                        r_next.done = 1'b1;
                        if (!req_i.power_flow) begin
                            r_next.resp.enable_out = 1'b0;
                        end else if (req_i.ptr_fault) begin
                            r_next.resp.err_code = `NCC_ERR_INDIRECT; // [RULE18]
                            r_next.resp.enable_out = 1'b0; // [RULE18]
                        end else begin
                            r_next.resp.enable_out = !(cv_ovf || cv_bad); // [RULE10] [RULE13]
                            r_next.resp.dest_we = !(cv_ovf || cv_bad); // [RULE13]
                            if (!(cv_ovf || cv_bad))
                                r_next.resp.value = cv_val;
                            if (req_i.op == int_to_byte_op || req_i.op == dint_to_int_op
                                || req_i.op == real_round_op || req_i.op == real_chop_op)
                                r_next.resp.overflow_flag = cv_ovf; // [RULE13]
                            if (req_i.op == decimal_to_int_op || req_i.op == int_to_decimal_op)
                                r_next.resp.invalid_decimal_flag = cv_bad; // [RULE10] [RULE11]
                        end
                    end
                end
            end
            st_len_a: begin
                r_next.len_a = mem_rdata_i;
                r_next.addr = r_reg.req.in2[15:0];
                r_next.st = st_len_b;
            end
            st_len_b: begin
                r_next.rd = 1'b0;
                r_next.st = st_idle;
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
                if (r_reg.len_a > `NCC_STR_MAX_LEN || mem_rdata_i > `NCC_STR_MAX_LEN // [RULE8]
                    || str_overrun(r_reg.req.in1[15:0], r_reg.len_a, r_reg.req.area_end)
                    || str_overrun(r_reg.req.in2[15:0], mem_rdata_i, r_reg.req.area_end)) begin
                    r_next.resp.fatal = 1'b1; // [RULE9]
                    r_next.resp.enable_out = 1'b0;
                end else if (r_reg.len_a != mem_rdata_i || r_reg.len_a == 8'h00) begin
                    r_next.resp.stack_top = stack_next(r_reg.req.comb, r_reg.req.stack_top,
                                                       (r_reg.len_a == mem_rdata_i) ^ str_hit);
                    r_next.resp.stack_push = (r_reg.req.comb == comb_load);
                end else begin
                    r_next.done = 1'b0;
                    r_next.busy = 1'b1;
                    r_next.rd = 1'b1;
                    r_next.idx = 8'h01;
                    r_next.addr = r_reg.req.in1[15:0] + 16'h0001;
                    r_next.st = st_ch_a;
                end
            end
            st_ch_a: begin
                r_next.ch = mem_rdata_i;
                r_next.addr = r_reg.req.in2[15:0] + {8'h00, r_reg.idx};
                r_next.st = st_ch_b;
            end
            st_ch_b: begin
                if (mem_rdata_i != r_reg.ch || r_reg.idx == r_reg.len_a) begin
                    r_next.rd = 1'b0;
                    r_next.busy = 1'b0;
                    r_next.done = 1'b1;
                    r_next.st = st_idle;
                    r_next.resp.stack_top = stack_next(r_reg.req.comb, r_reg.req.stack_top,
                                                       (mem_rdata_i == r_reg.ch) ^ str_hit);
                    r_next.resp.stack_push = (r_reg.req.comb == comb_load);
                end else begin
                    r_next.idx = r_reg.idx + 8'h01;
                    r_next.addr = r_reg.req.in1[15:0] + {8'h00, r_reg.idx} + 16'h0001;
                    r_next.st = st_ch_a;
                end
            end
            default: r_next.st = st_idle;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign resp_o     = r_reg.resp;
    assign done_o     = r_reg.done;
    assign busy_o     = r_reg.busy;
    assign mem_rd_o   = r_reg.rd;
    assign mem_addr_o = r_reg.addr;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_byte_unsigned;
        take && req_i.op == cmp_byte_op && req_i.rel == rel_lt && req_i.comb == comb_load
            && !req_i.ptr_fault
        |=> done_o && resp_o.stack_top == ($past(req_i.in1[7:0]) < $past(req_i.in2[7:0]));
    endproperty
    a_byte_unsigned: assert property (p_byte_unsigned) else $error("byte compare wrong"); // [RULE1]

    property p_int_signed;
        take && req_i.op == cmp_int_op && req_i.rel == rel_gt && req_i.comb == comb_load
            && !req_i.ptr_fault
        |=> resp_o.stack_top
            == ($signed($past(req_i.in1[15:0])) > $signed($past(req_i.in2[15:0])));
    endproperty
    a_int_signed: assert property (p_int_signed) else $error("int compare wrong"); // [RULE2]

    property p_and_comb;
        take && req_i.op == cmp_dint_op && req_i.comb == comb_and && !req_i.stack_top
            && !req_i.ptr_fault
        |=> !resp_o.stack_top && !resp_o.stack_push;
    endproperty
    a_and_comb: assert property (p_and_comb) else $error("AND with zero top not zero"); // [RULE3]

    property p_nan_fatal;
        take && nan_fault |=> resp_o.fatal && done_o ##1 resp_o.fatal && !busy_o;
    endproperty
    a_nan_fatal: assert property (p_nan_fatal) else $error("NaN compare not fatal"); // [RULE5]

    property p_ptr_fatal;
        take && req_i.op <= cmp_str_op && req_i.ptr_fault |=> resp_o.fatal && !mem_rd_o;
    endproperty
    a_ptr_fatal: assert property (p_ptr_fatal) else $error("indirect compare not fatal"); // [RULE6]

    property p_no_power_gate;
        take && req_i.op < cmp_str_op && !req_i.power_flow |=> done_o;
    endproperty
    a_no_power_gate: assert property (p_no_power_gate) else $error("compare skipped"); // [RULE7]

    property p_str_long;
        r_reg.st == st_len_b && mem_rdata_i > `NCC_STR_MAX_LEN |=> resp_o.fatal && done_o;
    endproperty
    a_str_long: assert property (p_str_long) else $error("long string not fatal"); // [RULE8]

    property p_str_done;
        take && req_i.op == cmp_str_op && !req_i.ptr_fault |-> ##[2:520] done_o;
    endproperty
    a_str_done: assert property (p_str_done) else $error("string compare hung"); // [RULE9]

    property p_dec_bad;
        take && req_i.op == decimal_to_int_op && req_i.power_flow && !req_i.ptr_fault
            && req_i.in1[3:0] > 4'h9
        |=> resp_o.invalid_decimal_flag && !resp_o.enable_out && !resp_o.dest_we;
    endproperty
    a_dec_bad: assert property (p_dec_bad) else $error("bad decimal accepted"); // [RULE10]

    property p_narrow_ovf;
        take && req_i.op == dint_to_int_op && req_i.power_flow && !req_i.ptr_fault
            && req_i.in1[31:15] == 17'h00001
        |=> resp_o.overflow_flag && !resp_o.enable_out && $stable(resp_o.value);
    endproperty
    a_narrow_ovf: assert property (p_narrow_ovf) else $error("narrowing overflow missed"); // [RULE13]

    property p_sign_ext;
        take && req_i.op == int_to_dint_op && req_i.power_flow && !req_i.ptr_fault
        |=> resp_o.dest_we && resp_o.value[31:16] == {16{$past(req_i.in1[15])}};
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("sign not extended"); // [RULE14]

    property p_ind_code;
        take && req_i.op > cmp_str_op && req_i.power_flow && req_i.ptr_fault
        |=> resp_o.err_code == `NCC_ERR_INDIRECT && !resp_o.enable_out && !resp_o.dest_we;
    endproperty
    a_ind_code: assert property (p_ind_code) else $error("indirect code missing"); // [RULE18]

    c_byte_cmp: cover property (take && req_i.op == cmp_byte_op);
    c_str_eq: cover property (r_reg.st == st_ch_b ##1 done_o && resp_o.stack_top);
    c_round: cover property (take && req_i.op == real_round_op ##1 resp_o.dest_we);
    c_fatal: cover property (take ##1 resp_o.fatal);

endmodule // ncc_unit

// ### tb/ncc_mem_model.sv
`timescale 1ns/10ps
module ncc_mem_model (
    input  wire logic        core_clk_i,
    input  wire logic        mem_rd_i,
    input  wire logic [15:0] mem_addr_i,
    output logic [7:0]       mem_rdata_o
);
    logic [7:0] mem [256] = '{default: 8'h00};
    logic [7:0] last_reg = 8'h00;
    // Same-cycle read; idle bus shows inverse of last byte
    assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i[7:0]] : ~last_reg;
    always_ff @(posedge core_clk_i) begin
        if (mem_rd_i) begin
            last_reg <= mem_rdata_o;
        end
    end
endmodule // ncc_mem_model

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import ncc_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic start = 1'b0;
    ncc_req_t req = '0;
    ncc_resp_t resp;
    logic done, busy, rd;
    logic [15:0] addr;
    logic [7:0] rdata;
    int errors = 0;
    int total_checks = 0;
    logic [31:0] pa [4] = '{32'h80, 32'h8000, 32'h80000000, 32'hBF800000};
    logic [31:0] pb [4] = '{32'h01, 32'h0001, 32'h00000001, 32'h3F800000};
    always #2 core_clk_i = ~core_clk_i;
    ncc_unit i_ncc_unit (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .start_i(start),
        .req_i(req), .mem_rdata_i(rdata), .resp_o(resp), .done_o(done), .busy_o(busy),
        .mem_rd_o(rd), .mem_addr_o(addr));
    ncc_mem_model i_ncc_mem_model (.core_clk_i(core_clk_i), .mem_rd_i(rd),
        .mem_addr_i(addr), .mem_rdata_o(rdata));
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rst();
        sys_rst_i = 1'b1;
        repeat (16) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
    endtask
    task automatic go(ncc_op_t op, logic [31:0] a, logic [31:0] b);
        int n = 0;
        req.op = op;
        req.in1 = a;
        req.in2 = b;
        start = 1'b1;
        @(negedge core_clk_i);
        start = 1'b0;
        while (done !== 1'b1 && n < 600) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n == 600) begin
            errors++;
            wrap_up();
        end
    endtask
    function automatic logic signed [32:0] ext(ncc_op_t op, logic [31:0] v);
        if (op == cmp_byte_op) return {25'h0, v[7:0]};
        if (op == cmp_int_op) return {{17{v[15]}}, v[15:0]};
        // Reals as sign and magnitude, both zeros equal
        if (op == cmp_real_op)
            return v[31] ? -$signed({2'b0, v[30:0]}) : $signed({2'b0, v[30:0]});
        return {v[31], v};
    endfunction
    function automatic logic exp_cmp(ncc_op_t op, ncc_rel_t r, ncc_comb_t cb,
                                     logic [31:0] a, logic [31:0] b, logic top);
        logic signed [32:0] x;
        logic signed [32:0] y;
        logic e;
        x = ext(op, a);
        y = ext(op, b);
        case (r)
            rel_eq: e = x == y;
            rel_ne: e = x != y;
            rel_ge: e = x >= y;
            rel_le: e = x <= y;
            rel_gt: e = x > y;
            default: e = x < y;
        endcase
        if (cb == comb_and) return e & top;
        if (cb == comb_or) return e | top;
        return e;
    endfunction
    // Both operands always carry the same type
    task automatic cmp(ncc_op_t op, ncc_rel_t r, ncc_comb_t cb, logic [31:0] a, logic [31:0] b);
        req.rel = r;
        req.comb = cb;
        req.stack_top = 1'($urandom_range(1));
        go(op, a, b);
        chk({31'h0, resp.stack_top}, {31'h0, exp_cmp(op, r, cb, a, b, req.stack_top)});
    endtask
    task automatic cnv(ncc_op_t op, logic [31:0] a, logic [31:0] v, logic ok);
        go(op, a, 32'h0);
        chk({31'h0, resp.enable_out}, {31'h0, ok});
        chk(resp.value, v);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        void'($urandom(89793));
        rst();
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 6; i++) begin
                req.power_flow = i[0];
                cmp(ncc_op_t'(k), ncc_rel_t'(i), ncc_comb_t'(i % 3), pa[k], pb[k]);
            end
        end
        repeat (40) begin
            cmp(ncc_op_t'($urandom_range(2)), ncc_rel_t'($urandom_range(5)),
                ncc_comb_t'($urandom_range(2)), $urandom, $urandom);
        end
        req.power_flow = 1'b1;
        cnv(byte_to_int_op, 32'hFF, 32'hFF, 1'b1);
        cnv(int_to_dint_op, 32'h8001, 32'hFFFF8001, 1'b1);
        cnv(dint_to_int_op, 32'h7FFF, 32'h7FFF, 1'b1);
        cnv(dint_to_int_op, 32'h8000, resp.value, 1'b0);
        chk({31'h0, resp.overflow_flag}, 32'h1);
        cnv(int_to_byte_op, 32'h100, resp.value, 1'b0);
        cnv(decimal_to_int_op, 32'h9999, 32'h270F, 1'b1);
        cnv(decimal_to_int_op, 32'h00A0, resp.value, 1'b0);
        chk({31'h0, resp.invalid_decimal_flag}, 32'h1);
        cnv(int_to_decimal_op, 32'h270F, 32'h9999, 1'b1);
        cnv(int_to_decimal_op, 32'h2710, resp.value, 1'b0);
        cnv(dint_to_real_op, 32'hFFFFFFFF, 32'hBF800000, 1'b1);
        cnv(real_round_op, 32'h40200000, 32'h3, 1'b1);
        cnv(real_round_op, 32'hC0200000, 32'hFFFFFFFD, 1'b1);
        cnv(real_chop_op, 32'h40200000, 32'h2, 1'b1);
        repeat (20) begin
            v = $urandom;
            cnv(int_to_dint_op, v, {{16{v[15]}}, v[15:0]}, 1'b1);
        end
        req.ptr_fault = 1'b1;
        cnv(real_chop_op, 32'h3F800000, resp.value, 1'b0);
        chk({16'h0, resp.err_code}, 32'h6);
        req.ptr_fault = 1'b0;
        req.area_end = 16'h0100;
        i_ncc_mem_model.mem[8'h10:8'h12] = '{8'h02, 8'h41, 8'h42};
        i_ncc_mem_model.mem[8'h20:8'h22] = '{8'h02, 8'h41, 8'h42};
        i_ncc_mem_model.mem[8'h30:8'h32] = '{8'h02, 8'h41, 8'h43};
        i_ncc_mem_model.mem[8'hFE] = 8'h02;
        i_ncc_mem_model.mem[8'h40] = 8'hFF;
        req.rel = rel_eq;
        req.comb = comb_load;
        go(cmp_str_op, 32'h10, 32'h20);
        chk({31'h0, resp.stack_top}, 32'h1);
        req.rel = rel_ne;
        go(cmp_str_op, 32'h10, 32'h30);
        chk({31'h0, resp.stack_top}, 32'h1);
        go(cmp_str_op, 32'hFE, 32'h10);
        chk({31'h0, resp.fatal}, 32'h1);
        start = 1'b1;
        @(negedge core_clk_i);
        start = 1'b0;
        repeat (3) @(negedge core_clk_i);
        chk({30'h0, busy, done}, 32'h0);
        rst();
        req.area_end = 16'hFFFF;
        go(cmp_str_op, 32'h40, 32'h10);
        chk({31'h0, resp.fatal}, 32'h1);
        rst();
        go(cmp_real_op, 32'h7FC00000, 32'h3F800000);
        chk({31'h0, resp.fatal}, 32'h1);
        rst();
        req.ptr_fault = 1'b1;
        go(cmp_int_op, 32'h1, 32'h1);
        chk({31'h0, resp.fatal}, 32'h1);
        wrap_up();
    end
endmodule // testbench
